// [src/uof_flag_if.sv]
// Interface between the register front end and one port's event flag logic.
// Assumes one clock domain; events are one-cycle pulses.
`timescale 1ns/1ps
interface uof_flag_if;
   import uof_pkg::*;
   logic [7:0] events;
   logic [7:0] clear;
   logic [7:0] flags;
   logic [1:0] line_state;
   modport det (output events, output line_state);
   modport reg_side (input events, input clear, output flags);
   modport bus (input flags, input line_state, output clear);
endinterface

// [src/uof_pkg.sv]
// Package for the USB OTG event flag block: register map, flag layout, timing counts.
// Assumes a 50 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package uof_pkg;
   localparam int unsigned UOF_CLK_HZ = 50000000;
   localparam int unsigned UOF_MS_TIME_US = 1000;
   localparam int unsigned UOF_MS_CYCLES = (UOF_CLK_HZ / 1000000) * UOF_MS_TIME_US;
   localparam int unsigned UOF_PORTS = 2;
   localparam int unsigned UOF_ADDR_W = 5;
   localparam logic [UOF_ADDR_W-1:0] UOF_FLAGS1_OFS = 5'h00;
   localparam logic [UOF_ADDR_W-1:0] UOF_FLAGS2_OFS = 5'h04;
   localparam logic [UOF_ADDR_W-1:0] UOF_MASK1_OFS = 5'h08;
   localparam logic [UOF_ADDR_W-1:0] UOF_MASK2_OFS = 5'h0c;
   localparam logic [UOF_ADDR_W-1:0] UOF_LINE1_OFS = 5'h10;
   localparam logic [UOF_ADDR_W-1:0] UOF_LINE2_OFS = 5'h14;
   localparam int unsigned UOF_ID_BIT = 7;
   localparam int unsigned UOF_MS_BIT = 6;
   localparam int unsigned UOF_LSTABLE_BIT = 5;
   localparam int unsigned UOF_ACT_BIT = 4;
   localparam int unsigned UOF_SESVD_BIT = 3;
   localparam int unsigned UOF_SESEND_BIT = 2;
   localparam int unsigned UOF_VBUS_BIT = 0;
   localparam logic [7:0] UOF_IMPL_MASK = 8'hfd;
   localparam logic [7:0] UOF_FLAGS_RESET = 8'h00;
   localparam logic [1:0] UOF_RESP_OKAY = 2'h0;
   localparam logic [1:0] UOF_RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic dplus;
      logic dminus;
      logic id;
      logic vbus_valid;
      logic sess_end;
      logic sess_valid;
      logic wake_enable;
   } uof_pins_type;
endpackage

// [src/uof_port_det.sv]
// Event detector for one USB OTG port: synchronises pins, runs the 1 ms timer
// and the line stability watch, and emits one-cycle event pulses.
// Assumes pins are asynchronous to aclk.
`timescale 1ns/1ps
module uof_port_det
   import uof_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire uof_pins_type pins,
   uof_flag_if.det fl
);
   uof_pins_type meta;
   uof_pins_type sync;
   uof_pins_type prev;
   logic [31:0] ms_count;
   logic [31:0] stable_count;
   logic [1:0] last_stable;
   logic [1:0] line_now;
   logic [1:0] line_prev;
   logic armed;
   logic ms_tick;
   logic stable_hit;
   logic wake_act;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= pins;
         sync <= meta;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev <= '0;
         armed <= 1'b0;
      end else begin
         prev <= sync;
         armed <= 1'b1;
      end
   end

   assign line_now = {sync.dplus, sync.dminus};
   assign line_prev = {prev.dplus, prev.dminus};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_count <= '0;
      end else if (ms_tick) begin
         ms_count <= '0;
      end else begin
         ms_count <= ms_count + 32'h1;
      end
   end
   assign ms_tick = (ms_count == UOF_MS_CYCLES - 1);

   // Count restarts on any line change; a hit fires once per stable period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stable_count <= '0;
         last_stable <= 2'h0;
      end else if (line_now != line_prev) begin
         stable_count <= '0;
      end else if (stable_count < UOF_MS_CYCLES) begin
         stable_count <= stable_count + 32'h1;
         if (stable_hit) begin
            last_stable <= line_now;
         end
      end
   end
   assign stable_hit = (stable_count == UOF_MS_CYCLES - 1) && (line_now == line_prev);

   // Wake-up activity only counts while the port is parked for wake
   assign wake_act = sync.wake_enable && (line_now != line_prev || sync.id != prev.id
      || sync.vbus_valid != prev.vbus_valid);

   always_comb begin
      fl.events = 8'h00;
      if (armed) begin
         fl.events[UOF_ID_BIT] = sync.id != prev.id;
         fl.events[UOF_ACT_BIT] = wake_act;
         // Rising session end input: VBUS has dropped below the end level
         fl.events[UOF_SESVD_BIT] = sync.sess_end && !prev.sess_end;
         fl.events[UOF_SESEND_BIT] = sync.sess_end != prev.sess_end;
         fl.events[UOF_VBUS_BIT] = sync.sess_valid != prev.sess_valid;
      end
      fl.events[UOF_MS_BIT] = ms_tick;
      fl.events[UOF_LSTABLE_BIT] = stable_hit && (line_now != last_stable);
   end

   assign fl.line_state = last_stable;
endmodule

// [src/uof_top.sv]
// Top of the USB OTG event flag block: AXI4-Lite slave, two ports of flags,
// mask registers and one level interrupt.
// Assumes AXI4-Lite master behaviour per the published protocol; pins asynchronous.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
module uof_top
   import uof_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [UOF_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [UOF_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire uof_pins_type port1_pins,
   input wire uof_pins_type port2_pins,
   output logic irq
);
   uof_flag_if fl1 ();
   uof_flag_if fl2 ();

   logic aw_held;
   logic w_held;
   logic [UOF_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic [7:0] mask1;
   logic [7:0] mask2;
   logic [7:0] flags1;
   logic [7:0] flags2;
   logic [7:0] next_flags1;
   logic [7:0] next_flags2;
   logic [7:0] clr1;
   logic [7:0] clr2;
   logic rd_ok;
   logic [31:0] rd_word;

   // Only a full-word aligned decode; low two address bits ignored
   function automatic logic [UOF_ADDR_W-1:0] word_addr(input logic [UOF_ADDR_W-1:0] a);
      word_addr = {a[UOF_ADDR_W-1:2], 2'b00};
   endfunction

   // Write-one-to-clear, set beats clear, reserved bits forced to zero
   function automatic logic [7:0] flag_update(input logic [7:0] cur, input logic [7:0] ev,
      input logic [7:0] clr);
      flag_update = ((cur & ~clr) | ev) & UOF_IMPL_MASK;
   endfunction

   uof_port_det u_det1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pins(port1_pins),
      .fl(fl1.det)
   );

   uof_port_det u_det2 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pins(port2_pins),
      .fl(fl2.det)
   );

   // Write channels taken independently; held until both present
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (wr_go) begin
         w_held <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
   end

   assign wr_go = aw_held && w_held;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= UOF_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         case (word_addr(aw_addr))
            UOF_FLAGS1_OFS, UOF_FLAGS2_OFS, UOF_MASK1_OFS, UOF_MASK2_OFS,
            UOF_LINE1_OFS, UOF_LINE2_OFS: s_axi_bresp <= UOF_RESP_OKAY;
            default: s_axi_bresp <= UOF_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only byte lane 0 carries flag and mask bits
   always_comb begin
      clr1 = 8'h00;
      clr2 = 8'h00;
      if (wr_go && w_strb[0]) begin
         if (word_addr(aw_addr) == UOF_FLAGS1_OFS) begin
            clr1 = w_data[7:0];
         end
         if (word_addr(aw_addr) == UOF_FLAGS2_OFS) begin
            clr2 = w_data[7:0];
         end
      end
   end

   assign fl1.clear = clr1;
   assign fl2.clear = clr2;
   assign next_flags1 = flag_update(flags1, fl1.events, fl1.clear);
   assign next_flags2 = flag_update(flags2, fl2.events, fl2.clear);

   // Two independent copies, one per port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags1 <= UOF_FLAGS_RESET;
         flags2 <= UOF_FLAGS_RESET;
      end else begin
         flags1 <= next_flags1;
         flags2 <= next_flags2;
      end
   end

   assign fl1.flags = flags1;
   assign fl2.flags = flags2;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask1 <= 8'h00;
         mask2 <= 8'h00;
      end else if (wr_go && w_strb[0]) begin
         if (word_addr(aw_addr) == UOF_MASK1_OFS) begin
            mask1 <= w_data[7:0] & UOF_IMPL_MASK;
         end
         if (word_addr(aw_addr) == UOF_MASK2_OFS) begin
            mask2 <= w_data[7:0] & UOF_IMPL_MASK;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_flags1 & mask1) || |(next_flags2 & mask2);
      end
   end

   // Read path: one read in flight, answer one cycle after address taken
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_ok = 1'b1;
      rd_word = 32'h0000_0000;
      case (word_addr(s_axi_araddr))
         UOF_FLAGS1_OFS: rd_word = {24'h000000, fl1.flags & UOF_IMPL_MASK};
         UOF_FLAGS2_OFS: rd_word = {24'h000000, fl2.flags & UOF_IMPL_MASK};
         UOF_MASK1_OFS: rd_word = {24'h000000, mask1};
         UOF_MASK2_OFS: rd_word = {24'h000000, mask2};
         UOF_LINE1_OFS: rd_word = {30'h0, fl1.line_state};
         UOF_LINE2_OFS: rd_word = {30'h0, fl2.line_state};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= UOF_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? UOF_RESP_OKAY : UOF_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the OTG event flag block.
// Assumes the cable models drive both pin bundles; expectations queue per bus reply.
`timescale 1ns/1ps
module tb_top;
   import uof_pkg::*;
   logic aclk, aresetn, irq;
   logic [UOF_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   uof_pins_type port1_pins, port2_pins;
   uof_pins_type pv[2];
   logic [33:0] exp_q[$];
   logic [6:0] tog[7] = '{7'h10, 7'h04, 7'h04, 7'h02, 7'h01, 7'h20, 7'h08};
   logic [7:0] ev[7] = '{8'h80, 8'h0c, 8'h04, 8'h01, 8'h00, 8'h10, 8'h10};
   logic [UOF_ADDR_W-1:0] fa[2] = '{UOF_FLAGS1_OFS, UOF_FLAGS2_OFS};
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int seed = 63476;
   uof_top u_uof_top(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .port1_pins, .port2_pins, .irq);
   uof_cable u_uof_cable(.aclk, .pins(port1_pins));
   uof_cable u_uof_cable2(.aclk, .pins(port2_pins));
   initial begin
      aclk = 0;
      forever #10 aclk = ~aclk;
   end
   task chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ad, wd;
      ad = 0;
      wd = 0;
      exp_q.push_back({r, 32'h0});
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awprot <= 3'($random(seed));
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            ad = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd = 1;
            s_axi_wvalid <= 0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
   endtask
   task rd(input logic [4:0] a, input logic [1:0] r, input logic [31:0] d);
      exp_q.push_back({r, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arprot <= 3'($random(seed));
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
   endtask
   task irq_is(input logic e);
      repeat (2) @(posedge aclk);
      chk({33'h0, irq}, {33'h0, e});
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (aresetn && s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, exp_q.size() ? exp_q.pop_front() : 'x);
      if (aresetn && s_axi_bvalid && s_axi_bready)
         chk({s_axi_bresp, 32'h0}, exp_q.size() ? exp_q.pop_front() : 'x);
      // Ceiling well above the one timer period of 50000 cycles the run needs
      if (cycles == 60000) begin
         num_errors++;
         print_verdict;
      end
   end
   initial begin
      aresetn = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      pv = '{default: '0};
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      rd(fa[0], UOF_RESP_OKAY, 32'h0);
      rd(fa[1], UOF_RESP_OKAY, 32'h0);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 7; i++) begin
            pv[p] = pv[p] ^ tog[i];
            if (p == 0) u_uof_cable.put(pv[p], $random(seed) & 3);
            else u_uof_cable2.put(pv[p], $random(seed) & 3);
            repeat (8) @(posedge aclk);
            rd(fa[p], UOF_RESP_OKAY, {24'h0, ev[i]});
            rd(fa[1 - p], UOF_RESP_OKAY, 32'h0);
            wr(fa[p], {24'h0, ev[i]}, UOF_RESP_OKAY);
         end
      end
      repeat (50100) @(posedge aclk);
      rd(fa[0], UOF_RESP_OKAY, 32'h60);
      rd(fa[1], UOF_RESP_OKAY, 32'h60);
      rd(UOF_LINE1_OFS, UOF_RESP_OKAY, 32'h1);
      wr(fa[0], $random(seed) & 32'hffffff02, UOF_RESP_OKAY);
      rd(fa[0], UOF_RESP_OKAY, 32'h60);
      wr(fa[0], 32'h20, UOF_RESP_OKAY);
      rd(fa[0], UOF_RESP_OKAY, 32'h40);
      wr(UOF_MASK1_OFS, 32'hff, UOF_RESP_OKAY);
      rd(UOF_MASK1_OFS, UOF_RESP_OKAY, 32'hfd);
      irq_is(1);
      wr(UOF_MASK1_OFS, 32'h0, UOF_RESP_OKAY);
      irq_is(0);
      wr(UOF_MASK1_OFS, 32'h40, UOF_RESP_OKAY);
      irq_is(1);
      wr(fa[0], 32'h40, UOF_RESP_OKAY);
      irq_is(0);
      wr(5'h18, 32'hff, UOF_RESP_SLVERR);
      rd(5'h18, UOF_RESP_SLVERR, 32'h0);
      print_verdict;
   end
endmodule

// [verification/uof_cable.sv]
// Cable and transceiver model for one OTG port: drives the pin bundle.
// Assumes the bench calls put() from its main sequence.
`timescale 1ns/1ps
module uof_cable
   import uof_pkg::*;
(
   input wire logic aclk,
   output uof_pins_type pins
);
   initial begin
      pins = '0;
   end
   // Lands mid-cycle, pins are asynchronous to aclk
   task automatic put(input uof_pins_type v, input int lag);
      repeat (lag + 1) @(posedge aclk);
      #7;
      pins = v;
   endtask
endmodule

// [verification/uof_properties.sv]
// Checker for the OTG event flag block, bound to the top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module uof_chk
   import uof_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_b_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write response late");
   property p_r_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read data late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data unstable");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("second read taken");
   property p_upper_zero;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
   property p_err_zero;
      s_axi_rvalid && s_axi_rresp == UOF_RESP_SLVERR |-> s_axi_rdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   // Flag clear drops irq as bvalid rises, a mask write one cycle later
   property p_irq_fall;
      $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid, 1);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell alone");
   property p_irq_reset;
      $rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid;
   endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("not idle after reset");
endmodule
bind uof_top uof_chk u_uof_chk(.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
